// file: design/tbp_pkg.sv
package tbp_pkg;
   // register indices; the bus byte address is four times the index
   localparam logic [7:0] IDX_COUNT_HIGH    = 8'h2e;
   localparam logic [7:0] IDX_COUNT_LOW     = 8'h2f;
   localparam logic [7:0] IDX_RESERVED      = 8'h30;
   localparam logic [7:0] IDX_BIT_SELECT    = 8'h31;
   localparam logic [7:0] IDX_GROUP_PRBS    = 8'h32;
   localparam logic [7:0] IDX_PIN_DRIVER_EN = 8'h33;
   localparam logic [7:0] IDX_PIN_LEVELS    = 8'h34;
   localparam logic [7:0] IDX_BUS_STATUS    = 8'h35;

   // reset values
   localparam logic [7:0] RST_BIT_SELECT    = 8'h00;
   localparam logic [7:0] RST_GROUP_PRBS    = 8'h00;
   localparam logic [7:0] RST_PIN_DRIVER_EN = 8'h80;
   localparam logic [7:0] RST_PIN_LEVELS    = 8'h00;
   localparam logic [7:0] RST_RESERVED      = 8'h00;

   // field positions
   localparam int BIT_SEL_MSB   = 2;
   localparam int GRP_SEL_MSB   = 4;
   localparam int POS_PRBS15    = 5;
   localparam int POS_PRBS9     = 6;
   localparam int POS_FLIP      = 7;
   localparam int POS_LINE_EN   = 7;
   localparam int POS_USE_IO    = 7;
   localparam int PIN_LSB       = 1;
   localparam int PIN_MSB       = 6;
   localparam int PINS          = 6;
   localparam int LIMITED_PINS  = 4;

   // aux-two selection code that routes the probe bit
   localparam logic [3:0] AUX_SEL_PROBE = 4'hf;

   // flipped parallel-port order, pin 6 down to pin 1
   localparam int FLIP_P6 = 4;
   localparam int FLIP_P5 = 3;
   localparam int FLIP_P4 = 2;
   localparam int FLIP_P3 = 6;
   localparam int FLIP_P2 = 5;
   localparam int FLIP_P1 = 0;

   // pseudo-random generators and seeds
   localparam logic [8:0]  PRBS9_SEED  = 9'h1ff;
   localparam logic [14:0] PRBS15_SEED = 15'h7fff;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : tbp_pkg

// file: design/tbp_test_port.sv
`timescale 1ns/1ps
// Behaviour
// R01 - low byte of the running timer count reads back, read only
// R02 - offset 30h is reserved and always reads zero
// R03 - three-bit selector picks the probe bit driven on the multipurpose pin
// R04 - aux-two selection all ones also routes the probe bit to aux pin two
// R05 - flip bit reorders probe bus onto pins as bits 4,3,2,6,5,0
// R06 - prbs9 bit arms the prbs9 sequence; transmit command starts it
// R07 - prbs15 bit arms the prbs15 sequence; transmit command starts it
// R08 - software sets up transmit registers before arming a sequence
// R09 - five-bit selector picks the probe group for pins and status byte
// R10 - serial line enable clear disables the serial aux lines; resets set
// R11 - six pin driver enables turn on each test data pin separately
// R12 - enable bit 1 drives data pin 1, bit 5 drives data pin 5
// R13 - with spi host only data pins 1 to 4 may drive
// R14 - with uart host and line enable set only pins 1 to 4 drive
// R15 - use-as-io makes the port general io under a serial host
// R16 - pin value field gives driven levels, only where enable bit is set
// R17 - use-as-io set: pin value byte reads the real pin levels
// R18 - use-as-io clear: pin value byte reads the stored value
// R19 - status byte shows the live selected probe group
// R20 - high byte of the timer count reads at its own offset
// R21 - reserved bits ignore writes and read zero
module tbp_test_port #(
   parameter int ADDR_WIDTH = 8,
   parameter int NUM_GROUPS = 32
) (
   // clock and reset
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // axi4-lite write address
   input  wire logic [ADDR_WIDTH-1:0]   s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_WIDTH-1:0]   s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // core side
   input  wire logic [15:0]             timer_count,
   input  wire logic [NUM_GROUPS*8-1:0] probe_groups,
   input  wire logic [3:0]              aux_two_analog_selection,
   input  wire logic                    host_if_spi,
   input  wire logic                    host_if_uart,
   input  wire logic                    host_if_i2c,
   input  wire logic                    transmit_cmd,
   // prbs transmit stream
   output logic                         prbs_tx_active,
   output logic                         prbs_tx_bit,
   // test pins
   output logic                         multipurpose_output_pin,
   output logic                         auxiliary_pin_two_out,
   output logic                         auxiliary_pin_two_oe,
   output logic                         serial_aux_lines_en,
   input  wire logic [5:0]              test_pin_in,
   output logic [5:0]                   test_pin_out,
   output logic [5:0]                   test_pin_oe
);

   if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_addr_width
      $error("ADDR_WIDTH must lie between 8 and 32");
   end
   if (NUM_GROUPS < 1 || NUM_GROUPS > 32) begin : g_bad_num_groups
      $error("NUM_GROUPS must lie between 1 and 32");
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers and internal state

   logic [2:0]              bit_sel_q;
   logic                    flip_q;
   logic                    prbs9_en_q;
   logic                    prbs15_en_q;
   logic [4:0]              grp_sel_q;
   logic                    line_en_q;
   logic [5:0]              pin_en_q;
   logic                    use_io_q;
   logic [5:0]              pin_val_q;
   logic [5:0]              pin_meta_q;
   logic [5:0]              pin_sync_q;
   logic [7:0]              status_q;
   logic [8:0]              lfsr9_q;
   logic [14:0]             lfsr15_q;
   logic [ADDR_WIDTH-1:0]   awaddr_q;
   logic [31:0]             wdata_q;
   logic [3:0]              wstrb_q;
   logic [7:0]              group_byte;
   logic [5:0]              mapped;
   logic [5:0]              pin_allow;
   logic                    serial_host;
   logic                    io_mode;
   logic                    wr_fire;
   logic                    wr_hit;
   logic [7:0]              wr_idx;
   logic [7:0]              rd_idx;
   logic [7:0]              rd_byte;
   logic                    rd_hit;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write path: address and data are taken in either order

   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_idx  = awaddr_q[ADDR_WIDTH-1:2] > (ADDR_WIDTH-2)'(8'hff) ? 8'hff
                    : 8'(awaddr_q[ADDR_WIDTH-1:2]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         awaddr_q      <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         awaddr_q      <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         wdata_q      <= '0;
         wstrb_q      <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         wdata_q      <= s_axi_wdata;
         wstrb_q      <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   // read-only and reserved offsets accept the write and change nothing
   always_comb begin
      wr_hit = 1'b0;
      if (wr_idx >= tbp_pkg::IDX_COUNT_HIGH && wr_idx <= tbp_pkg::IDX_BUS_STATUS) begin
         wr_hit = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= tbp_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? tbp_pkg::RESP_OKAY : tbp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software-written registers; only byte lane 0 carries data

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bit_sel_q <= tbp_pkg::RST_BIT_SELECT[2:0];
      end else if (wr_fire && wstrb_q[0] && wr_idx == tbp_pkg::IDX_BIT_SELECT) begin
         bit_sel_q <= wdata_q[tbp_pkg::BIT_SEL_MSB:0]; // [R03] [R21]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flip_q      <= tbp_pkg::RST_GROUP_PRBS[tbp_pkg::POS_FLIP];
         prbs9_en_q  <= tbp_pkg::RST_GROUP_PRBS[tbp_pkg::POS_PRBS9];
         prbs15_en_q <= tbp_pkg::RST_GROUP_PRBS[tbp_pkg::POS_PRBS15];
         grp_sel_q   <= tbp_pkg::RST_GROUP_PRBS[4:0];
      end else if (wr_fire && wstrb_q[0] && wr_idx == tbp_pkg::IDX_GROUP_PRBS) begin
         flip_q      <= wdata_q[tbp_pkg::POS_FLIP];
         prbs9_en_q  <= wdata_q[tbp_pkg::POS_PRBS9];    // [R06]
         prbs15_en_q <= wdata_q[tbp_pkg::POS_PRBS15];   // [R07]
         grp_sel_q   <= wdata_q[tbp_pkg::GRP_SEL_MSB:0]; // [R09]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_en_q <= tbp_pkg::RST_PIN_DRIVER_EN[tbp_pkg::POS_LINE_EN]; // [R10]
         pin_en_q  <= tbp_pkg::RST_PIN_DRIVER_EN[tbp_pkg::PIN_MSB:tbp_pkg::PIN_LSB];
      end else if (wr_fire && wstrb_q[0] && wr_idx == tbp_pkg::IDX_PIN_DRIVER_EN) begin
         line_en_q <= wdata_q[tbp_pkg::POS_LINE_EN];
         pin_en_q  <= wdata_q[tbp_pkg::PIN_MSB:tbp_pkg::PIN_LSB]; // [R11] [R21]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         use_io_q  <= tbp_pkg::RST_PIN_LEVELS[tbp_pkg::POS_USE_IO];
         pin_val_q <= tbp_pkg::RST_PIN_LEVELS[tbp_pkg::PIN_MSB:tbp_pkg::PIN_LSB];
      end else if (wr_fire && wstrb_q[0] && wr_idx == tbp_pkg::IDX_PIN_LEVELS) begin
         use_io_q  <= wdata_q[tbp_pkg::POS_USE_IO];
         pin_val_q <= wdata_q[tbp_pkg::PIN_MSB:tbp_pkg::PIN_LSB]; // [R16] [R21]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // probe bus selection and pin mapping

   // a selector beyond the built groups shows zero rather than wrapping
   always_comb begin
      group_byte = 8'h00;
      if (int'(grp_sel_q) < NUM_GROUPS) begin
         group_byte = probe_groups[grp_sel_q*8 +: 8]; // [R09]
      end
   end

   always_comb begin
      if (flip_q) begin
         mapped = {group_byte[tbp_pkg::FLIP_P6], group_byte[tbp_pkg::FLIP_P5],
                   group_byte[tbp_pkg::FLIP_P4], group_byte[tbp_pkg::FLIP_P3],
                   group_byte[tbp_pkg::FLIP_P2], group_byte[tbp_pkg::FLIP_P1]}; // [R05]
      end else begin
         mapped = group_byte[5:0];
      end
   end

   // pins 5 and 6 double as host lines under spi or uart with line enable
   assign serial_host = host_if_spi || host_if_uart || host_if_i2c;
   assign io_mode     = use_io_q && serial_host; // [R15]
   always_comb begin
      pin_allow = '1;
      if (host_if_spi || (host_if_uart && line_en_q)) begin
         pin_allow = 6'((1 << tbp_pkg::LIMITED_PINS) - 1); // [R13] [R14]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         test_pin_out <= '0;
         test_pin_oe  <= '0;
      end else begin
         test_pin_out <= io_mode ? pin_val_q : mapped; // [R16]
         test_pin_oe  <= pin_en_q & pin_allow;         // [R11] [R12] [R15]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         multipurpose_output_pin <= 1'b0;
         auxiliary_pin_two_out   <= 1'b0;
         auxiliary_pin_two_oe    <= 1'b0;
         serial_aux_lines_en     <= 1'b0;
      end else begin
         multipurpose_output_pin <= group_byte[bit_sel_q]; // [R03]
         auxiliary_pin_two_out   <= group_byte[bit_sel_q]; // [R04]
         auxiliary_pin_two_oe    <= aux_two_analog_selection == tbp_pkg::AUX_SEL_PROBE; // [R04]
         serial_aux_lines_en     <= line_en_q; // [R10]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin level synchroniser and live status capture

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= test_pin_in;
         pin_sync_q <= pin_meta_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= 8'h00;
      end else begin
         status_q <= group_byte; // [R19]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // prbs generators: armed by the enable bits, started by transmit

   // both armed: prbs9 wins; the stream stops only when both arm bits clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prbs_tx_active <= 1'b0;
      end else if (!prbs9_en_q && !prbs15_en_q) begin
         prbs_tx_active <= 1'b0;
      end else if (transmit_cmd) begin
         prbs_tx_active <= 1'b1; // [R06] [R07]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !prbs9_en_q) begin
         lfsr9_q <= tbp_pkg::PRBS9_SEED;
      end else if (prbs_tx_active) begin
         lfsr9_q <= {lfsr9_q[7:0], lfsr9_q[8] ^ lfsr9_q[4]}; // [R06]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !prbs15_en_q) begin
         lfsr15_q <= tbp_pkg::PRBS15_SEED;
      end else if (prbs_tx_active) begin
         lfsr15_q <= {lfsr15_q[13:0], lfsr15_q[14] ^ lfsr15_q[13]}; // [R07]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prbs_tx_bit <= 1'b0;
      end else if (!prbs_tx_active || (!prbs9_en_q && !prbs15_en_q)) begin
         // falls with the active flag, else a seed bit would leak one idle cycle
         prbs_tx_bit <= 1'b0;
      end else begin
         prbs_tx_bit <= prbs9_en_q ? lfsr9_q[8] : lfsr15_q[14];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read path

   assign rd_idx = s_axi_araddr[ADDR_WIDTH-1:2] > (ADDR_WIDTH-2)'(8'hff) ? 8'hff
                   : 8'(s_axi_araddr[ADDR_WIDTH-1:2]);

   always_comb begin
      rd_byte = 8'h00;
      rd_hit  = 1'b1;
      if (rd_idx == tbp_pkg::IDX_COUNT_HIGH) begin
         rd_byte = timer_count[15:8]; // [R20]
      end else if (rd_idx == tbp_pkg::IDX_COUNT_LOW) begin
         rd_byte = timer_count[7:0]; // [R01]
      end else if (rd_idx == tbp_pkg::IDX_RESERVED) begin
         rd_byte = tbp_pkg::RST_RESERVED; // [R02]
      end else if (rd_idx == tbp_pkg::IDX_BIT_SELECT) begin
         rd_byte = {5'h00, bit_sel_q}; // [R21]
      end else if (rd_idx == tbp_pkg::IDX_GROUP_PRBS) begin
         rd_byte = {flip_q, prbs9_en_q, prbs15_en_q, grp_sel_q};
      end else if (rd_idx == tbp_pkg::IDX_PIN_DRIVER_EN) begin
         rd_byte = {line_en_q, pin_en_q, 1'b0}; // [R21]
      end else if (rd_idx == tbp_pkg::IDX_PIN_LEVELS) begin
         rd_byte = {use_io_q, use_io_q ? pin_sync_q : pin_val_q, 1'b0}; // [R17] [R18]
      end else if (rd_idx == tbp_pkg::IDX_BUS_STATUS) begin
         rd_byte = status_q; // [R19]
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= tbp_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h000000, rd_byte};
         s_axi_rresp   <= rd_hit ? tbp_pkg::RESP_OKAY : tbp_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

endmodule // tbp_test_port

// file: dv/tbp_test_port_props.sv
`timescale 1ns/1ps
module tbp_test_port_props (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // pins and stream
   input wire logic        host_if_spi,
   input wire logic [5:0]  test_pin_oe,
   input wire logic        prbs_tx_active,
   input wire logic        prbs_tx_bit
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write answer not two cycles after request");
   r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer not one cycle after request");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped before taken");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed before taken");
   rdata_top_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while answer pending");
   read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");
   spi_pins_a: assert property ($past(host_if_spi) |-> test_pin_oe[5:4] == 2'h0)
      else $error("upper test pins driven under spi host");
   prbs_idle_a: assert property (!prbs_tx_active |-> !prbs_tx_bit)
      else $error("sequence bit high while idle");
endmodule // tbp_test_port_props

// file: dv/tbp_pin_partner.sv
`timescale 1ns/1ps
module tbp_pin_partner (
   // clock
   input wire logic       aclk,
   // device side
   input wire logic [5:0] test_pin_out,
   input wire logic [5:0] test_pin_oe,
   // equipment drive
   input wire logic [5:0] ext_val,
   input wire logic       ext_en,
   output logic [5:0]     pad
);
   logic [5:0] drift_q = 6'h15;
   // a released pin must not keep a level, or a missed read-back would go unseen
   always_ff @(posedge aclk) drift_q <= ~drift_q;
   always_comb begin
      for (int i = 0; i < 6; i++) pad[i] = test_pin_oe[i] ? test_pin_out[i] :
         (ext_en ? ext_val[i] : drift_q[i]);
   end
endmodule // tbp_pin_partner

// file: dv/tbp_test_port_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module tbp_test_port_test;
   logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, transmit_cmd = 1'h0;
   logic host_if_spi = 1'h0, host_if_uart = 1'h0, host_if_i2c = 1'h0, ext_en = 1'h0;
   logic [7:0]   s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, rd;
   logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]   s_axi_wstrb = 4'h0, aux_two_analog_selection = 4'h0;
   logic [15:0]  timer_count = 16'h0;
   logic [255:0] probe_groups;
   logic [5:0]   ext_val = 6'h0, test_pin_out, test_pin_oe, pad;
   logic [1:0]   s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic prbs_tx_active, prbs_tx_bit, multipurpose_output_pin, auxiliary_pin_two_out;
   logic auxiliary_pin_two_oe, serial_aux_lines_en;
   logic bits [60];
   int error_cnt = 0, tests_run = 0;
   always #2.5 aclk = ~aclk;
   tbp_test_port #(.ADDR_WIDTH(8), .NUM_GROUPS(32)) DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_count(timer_count),
      .probe_groups(probe_groups), .aux_two_analog_selection(aux_two_analog_selection),
      .host_if_spi(host_if_spi), .host_if_uart(host_if_uart), .host_if_i2c(host_if_i2c),
      .transmit_cmd(transmit_cmd), .prbs_tx_active(prbs_tx_active), .prbs_tx_bit(prbs_tx_bit),
      .multipurpose_output_pin(multipurpose_output_pin),
      .auxiliary_pin_two_out(auxiliary_pin_two_out), .auxiliary_pin_two_oe(auxiliary_pin_two_oe),
      .serial_aux_lines_en(serial_aux_lines_en), .test_pin_in(pad),
      .test_pin_out(test_pin_out), .test_pin_oe(test_pin_oe));
   tbp_pin_partner u_partner (.aclk(aclk), .test_pin_out(test_pin_out),
      .test_pin_oe(test_pin_oe), .ext_val(ext_val), .ext_en(ext_en), .pad(pad));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] grp(input int g);
      return 8'h96 ^ 8'(g * 37);
   endfunction
   task automatic results;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic settle;
      repeat (3) @(posedge aclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st = 4'h1,
                     input logic [1:0] er = 2'h0);
      logic aw_ok, w_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      @(posedge aclk);
      s_axi_awaddr <= {idx[5:0], 2'h0};
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= st;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready) begin aw_ok = 1'h1; s_axi_awvalid <= 1'h0; end
         if (!w_ok && s_axi_wready) begin w_ok = 1'h1; s_axi_wvalid <= 1'h0; end
      end while (!(aw_ok && w_ok));
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      `CHK(s_axi_bresp, er)
   endtask
   task automatic rdr(input logic [7:0] idx, input logic [1:0] er = 2'h0);
      @(posedge aclk);
      s_axi_araddr <= {idx[5:0], 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      rd = s_axi_rdata[7:0];
      s_axi_rready <= 1'h0;
      `CHK(s_axi_rresp, er)
   endtask
   task automatic chk(input logic [7:0] idx, input logic [7:0] e);
      rdr(idx);
      `CHK(rd, e)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
      foreach (rv[i]) chk(8'h30 + 8'(i), rv[i]);
      `CHK(serial_aux_lines_en, 1'h1)
      $display("test reset done");
   endtask
   task automatic t_regs;
      wr(8'h30, 8'hff); chk(8'h30, 8'h00);
      wr(8'h31, 8'hff); chk(8'h31, 8'h07);
      wr(8'h33, 8'hff); chk(8'h33, 8'hfe);
      wr(8'h34, 8'h7f); chk(8'h34, 8'h7e);
      wr(8'h34, 8'h00, 4'h0); chk(8'h34, 8'h7e);
      wr(8'h10, 8'h55, 4'h1, 2'h2); rdr(8'h10, 2'h2); `CHK(rd, 8'h00)
      @(posedge aclk) timer_count <= 16'ha55a;
      wr(8'h2f, 8'h00); chk(8'h2f, 8'h5a);
      chk(8'h2e, 8'ha5);
      $display("test registers done");
   endtask
   task automatic t_probe;
      logic [7:0] gb;
      @(posedge aclk) aux_two_analog_selection <= 4'hf;
      for (int g = 3; g < 32; g += 9) begin
         gb = grp(g);
         wr(8'h32, 8'(g)); chk(8'h35, gb);
         settle; `CHK(test_pin_out, gb[5:0])
         for (int b = 0; b < 8; b++) begin
            wr(8'h31, 8'(b)); settle;
            `CHK(multipurpose_output_pin, gb[b])
            `CHK({auxiliary_pin_two_oe, auxiliary_pin_two_out}, {1'h1, gb[b]})
         end
         wr(8'h32, 8'h80 | 8'(g)); settle;
         `CHK(test_pin_out, {gb[4], gb[3], gb[2], gb[6], gb[5], gb[0]})
      end
      @(posedge aclk) aux_two_analog_selection <= 4'h3;
      settle; `CHK(auxiliary_pin_two_oe, 1'h0)
      $display("test probe done");
   endtask
   task automatic oe_case(input logic spi, uart, input logic [7:0] r, input logic [6:0] e);
      @(posedge aclk) {host_if_spi, host_if_uart} <= {spi, uart};
      wr(8'h33, r); settle;
      `CHK({serial_aux_lines_en, test_pin_oe}, e)
   endtask
   task automatic t_oe;
      oe_case(1'h0, 1'h0, 8'h7e, 7'h3f);
      oe_case(1'h0, 1'h0, 8'h02, 7'h01);
      oe_case(1'h0, 1'h0, 8'h20, 7'h10);
      oe_case(1'h1, 1'h0, 8'hfe, 7'h4f);
      oe_case(1'h0, 1'h1, 8'hfe, 7'h4f);
      oe_case(1'h0, 1'h1, 8'h7e, 7'h3f);
      $display("test pin enables done");
   endtask
   task automatic t_io;
      @(posedge aclk);
      ext_val <= 6'h2a;
      ext_en <= 1'h1;
      wr(8'h33, 8'h2a); wr(8'h34, 8'hda); settle;
      `CHK(test_pin_oe, 6'h15)
      `CHK(test_pin_out & 6'h15, 6'h05)
      rdr(8'h34); `CHK(rd[6:1], 6'h2f)
      @(posedge aclk) {host_if_uart, host_if_i2c} <= 2'h1; settle;
      `CHK(test_pin_out & 6'h15, 6'h05)
      // no host: flipped group 30 (c0h) shows again on the driven pins
      @(posedge aclk) host_if_i2c <= 1'h0; settle;
      `CHK(test_pin_out & 6'h15, 6'h04)
      @(posedge aclk) ext_en <= 1'h0;
      wr(8'h34, 8'h5a); chk(8'h34, 8'h5a);
      $display("test io mode done");
   endtask
   task automatic run_seq(input logic [7:0] mode, input int s1, s2, len);
      int ha, hb, ones;
      ha = 0;
      hb = 0;
      ones = 0;
      wr(8'h32, mode); settle; // transmit setup was completed beforehand
      `CHK(prbs_tx_active, 1'h0)
      @(posedge aclk) transmit_cmd <= 1'h1;
      @(posedge aclk) transmit_cmd <= 1'h0;
      repeat (2) @(posedge aclk);
      `CHK(prbs_tx_active, 1'h1)
      foreach (bits[i]) begin @(posedge aclk); bits[i] = prbs_tx_bit; ones += int'(bits[i]); end
      for (int n = 15; n < 60; n++) begin
         ha += int'(bits[n] === (bits[n - s1] ^ bits[n - len]));
         hb += int'(bits[n] === (bits[n - s2] ^ bits[n - len]));
      end
      `CHK((ha == 45 || hb == 45) && ones > 0, 1'h1)
      wr(8'h32, 8'h00); settle;
      `CHK(prbs_tx_active, 1'h0)
   endtask
   task automatic t_prbs;
      run_seq(8'h40, 5, 4, 9);
      run_seq(8'h20, 14, 1, 15);
      $display("test sequences done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int g = 0; g < 32; g++) probe_groups[g * 8 +: 8] = grp(g);
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset;
      t_regs;
      t_probe;
      t_oe;
      t_io;
      t_prbs;
      results;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      results;
   end
endmodule // tbp_test_port_test
bind tbp_test_port tbp_test_port_props u_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .host_if_spi(host_if_spi),
   .test_pin_oe(test_pin_oe), .prbs_tx_active(prbs_tx_active), .prbs_tx_bit(prbs_tx_bit));
